// ### src/pwm_out_pkg.sv
// Notes on behaviour
// - Fault polarity bit selects active-low fault
// - Fault mode 11: no override, event still
// - Mode 01 forces fault states per cycle
// - Mode 00 latches fault states until cleared
// - Fault mode changes apply at cycle boundary
// - Switching to disabled keeps active override
// - Current limit enable and current limit input have no effect
// - High ownership bit gives high pin
// - Low ownership bit gives low pin
// - Polarity bits make pins active-low
// - Pair mode 11 holds low output inactive
// - Pair modes: complementary, redundant, push-pull, low-off
// - High override uses upper override bit
// - Low override uses lower override bit
// - Lock fuse 0 needs key before write
// - Lock fuse 1 allows writes any time
// - Forced values are active levels, polarity adjusted
// - Fault source routable from fourteen inputs
// - Fault state bits only used during fault
// - Four-bit field selects fault input
// - Override sync bit picks time base or clock
package pwm_out_pkg;
   // Register indices and byte addresses
   localparam logic [7:0]  ADDR_CTRL       = 8'h00;
   localparam logic [7:0]  ADDR_KEY        = 8'h04;
   localparam logic [7:0]  ADDR_STAT       = 8'h08;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
   localparam logic [31:0] KEY_FIRST       = 32'h0000_ABCD;
   localparam logic [31:0] KEY_SECOND      = 32'h0000_4321;
   // Control field positions
   localparam int          POS_CL_EN       = 24;
   localparam int          POS_FSRC        = 19;
   localparam int          POS_FPOL        = 18;
   localparam int          POS_FMOD        = 16;
   localparam int          POS_OWN_H       = 15;
   localparam int          POS_OWN_L       = 14;
   localparam int          POS_POL_H       = 13;
   localparam int          POS_POL_L       = 12;
   localparam int          POS_PIN_PAIR_MODE        = 10;
   localparam int          POS_OVR_H       = 9;
   localparam int          POS_OVR_L       = 8;
   localparam int          POS_OVERRIDE_PIN_STATES      = 6;
   localparam int          POS_FAULT_PIN_STATES      = 4;
   localparam int          POS_OVERRIDE_SYNC_SELECT       = 0;
   // Implemented control bits; others read zero
   localparam logic [31:0] CTRL_MASK       = 32'h01FF_FFF1;
   // Fault modes
   localparam logic [1:0]  FMOD_LATCH      = 2'h0;
   localparam logic [1:0]  FMOD_CYCLE      = 2'h1;
   localparam logic [1:0]  FMOD_OFF        = 2'h3;
   // Pin pair modes
   localparam logic [1:0]  PIN_PAIR_MODE_COMP       = 2'h0;
   localparam logic [1:0]  PIN_PAIR_MODE_REDUN      = 2'h1;
   localparam logic [1:0]  PIN_PAIR_MODE_PUSH       = 2'h2;
   localparam logic [1:0]  PIN_PAIR_MODE_LOWOFF     = 2'h3;

   // Unlock sequence states
   typedef enum logic [2:0] {
      KEY_IDLE = 3'b001,
      KEY_HALF = 3'b010,
      KEY_OPEN = 3'b100
   } key_state_t;

   // Register bus request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_t;

   // Whole module state
   typedef struct packed {
      logic [31:0] ctrl;
      logic [1:0]  fmod_act;
      key_state_t  key;
      logic        fault_sync;
      logic        fault_latch;
      logic        fault_force;
      logic        fault_event;
      logic        ovr_h;
      logic        ovr_l;
      logic [1:0]  ovr_dat;
      logic        pin_h;
      logic        pin_l;
      logic        oe_h;
      logic        oe_l;
      logic [31:0] rdata;
   } state_t;
endpackage : pwm_out_pkg

// ### src/pwm_output_fault_override_control.sv
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/10ps
module pwm_output_fault_override_control (
   // Clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RESET_N,
   // Register port
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [31:0] RDATA,
   // Fuse and time base
   input  wire logic        CONFIG_LOCK_FUSE,
   input  wire logic        MODULE_ENABLE,
   input  wire logic        CYCLE_START,
   // Generator waveform and sources
   input  wire logic        PWM_WAVE_H,
   input  wire logic        PWM_WAVE_L,
   input  wire logic [15:0] FAULT_SOURCES,
   input  wire logic        CURRENT_LIMIT_ACTIVE,
   // Power stage pins
   output logic             HIGH_SIDE_OUT,
   output logic             HIGH_SIDE_OE,
   output logic             LOW_SIDE_OUT,
   output logic             LOW_SIDE_OE,
   output logic             FAULT_EVENT
);
   pwm_out_pkg::state_t   st_ff;
   pwm_out_pkg::state_t   nxt_st;
   pwm_out_pkg::bus_req_t req;
   logic                  fault_raw;
   logic                  boundary;
   logic                  h_act;
   logic                  l_act;

   // Valid fault source: codes 13 and 14 are reserved and read inactive
   function automatic logic src_valid(input logic [3:0] code);
      src_valid = (code != 4'hD) && (code != 4'hE);
   endfunction : src_valid

   assign req      = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
   assign boundary = MODULE_ENABLE && CYCLE_START;

   // Source select and polarity of the chosen fault input
   always_comb begin
      fault_raw = 1'b0;
      if (src_valid(st_ff.ctrl[pwm_out_pkg::POS_FSRC +: 4])) begin
         fault_raw = FAULT_SOURCES[st_ff.ctrl[pwm_out_pkg::POS_FSRC +: 4]] ^
                     st_ff.ctrl[pwm_out_pkg::POS_FPOL];
      end
   end

   // Next state
   always_comb begin
      logic wr_ok;
      logic force_now;
      nxt_st = st_ff;
      wr_ok  = 1'b0;
      force_now = 1'b0;
      h_act  = 1'b0;
      l_act  = 1'b0;

      // Unlock sequence; any other access drops the key
      if (req.wr || req.rd) begin
         nxt_st.key = pwm_out_pkg::KEY_IDLE;
         if (req.wr && req.addr == pwm_out_pkg::ADDR_KEY) begin
            if (req.wdata == pwm_out_pkg::KEY_FIRST) begin
               nxt_st.key = pwm_out_pkg::KEY_HALF;
            end else if (req.wdata == pwm_out_pkg::KEY_SECOND && st_ff.key == pwm_out_pkg::KEY_HALF) begin
               nxt_st.key = pwm_out_pkg::KEY_OPEN;
            end
         end
      end
      wr_ok = CONFIG_LOCK_FUSE || (st_ff.key == pwm_out_pkg::KEY_OPEN);
      if (req.wr && req.addr == pwm_out_pkg::ADDR_CTRL && wr_ok) begin
         nxt_st.ctrl = req.wdata & pwm_out_pkg::CTRL_MASK;
      end

      // Read path, answered in the next cycle
      nxt_st.rdata = 32'h0000_0000;
      if (req.rd) begin
         unique case (req.addr)
            pwm_out_pkg::ADDR_CTRL: nxt_st.rdata = st_ff.ctrl;
            pwm_out_pkg::ADDR_STAT: nxt_st.rdata = {28'h0000000, st_ff.key == pwm_out_pkg::KEY_OPEN,
                                                    st_ff.fault_latch, st_ff.fault_force, st_ff.fault_sync};
            default:                nxt_st.rdata = 32'h0000_0000;
         endcase
      end

      // Fault input registered once, events raised in every mode
      nxt_st.fault_sync  = fault_raw;
      nxt_st.fault_event = fault_raw && !st_ff.fault_sync;

      // Mode changes adopted only at cycle boundaries; disabling keeps an active override
      if (boundary) begin
         if (!(st_ff.ctrl[pwm_out_pkg::POS_FMOD +: 2] == pwm_out_pkg::FMOD_OFF && st_ff.fault_force &&
               st_ff.fault_sync)) begin
            nxt_st.fmod_act = st_ff.ctrl[pwm_out_pkg::POS_FMOD +: 2];
         end
      end

      // Latched mode holds until a boundary with mode changed away and fault gone
      if (st_ff.fault_sync && st_ff.fmod_act == pwm_out_pkg::FMOD_LATCH) begin
         nxt_st.fault_latch = 1'b1;
      end else if (boundary && !st_ff.fault_sync && st_ff.ctrl[pwm_out_pkg::POS_FMOD +: 2] != pwm_out_pkg::FMOD_LATCH) begin
         nxt_st.fault_latch = 1'b0;
      end

      // Cycle-by-cycle: set at once, released at the next boundary without fault
      if (st_ff.fault_sync && st_ff.fmod_act != pwm_out_pkg::FMOD_OFF) begin
         force_now = 1'b1;
      end else if (boundary) begin
         force_now = 1'b0;
      end else begin
         force_now = st_ff.fault_force;
      end
      nxt_st.fault_force = force_now || nxt_st.fault_latch;

      // Overrides: synchronous to time base or taken at once
      if (!st_ff.ctrl[pwm_out_pkg::POS_OVERRIDE_SYNC_SELECT] || boundary) begin
         nxt_st.ovr_h   = st_ff.ctrl[pwm_out_pkg::POS_OVR_H];
         nxt_st.ovr_l   = st_ff.ctrl[pwm_out_pkg::POS_OVR_L];
         nxt_st.ovr_dat = st_ff.ctrl[pwm_out_pkg::POS_OVERRIDE_PIN_STATES +: 2];
      end

      // Pin pair modes on active levels
      unique case (st_ff.ctrl[pwm_out_pkg::POS_PIN_PAIR_MODE +: 2])
         pwm_out_pkg::PIN_PAIR_MODE_COMP: begin
            h_act = PWM_WAVE_H;
            l_act = !PWM_WAVE_H;
         end
         pwm_out_pkg::PIN_PAIR_MODE_REDUN: begin
            h_act = PWM_WAVE_H;
            l_act = PWM_WAVE_H;
         end
         pwm_out_pkg::PIN_PAIR_MODE_PUSH: begin
            h_act = PWM_WAVE_H;
            l_act = PWM_WAVE_L;
         end
         pwm_out_pkg::PIN_PAIR_MODE_LOWOFF: begin
            h_act = PWM_WAVE_H;
            l_act = 1'b0;
         end
      endcase
      // Software override, then fault above it; current limit input and enable bit have no effect
      if (st_ff.ovr_h) h_act = st_ff.ovr_dat[1];
      if (st_ff.ovr_l) l_act = st_ff.ovr_dat[0];
      if (st_ff.fault_force) begin
         h_act = st_ff.ctrl[pwm_out_pkg::POS_FAULT_PIN_STATES + 1];
         l_act = st_ff.ctrl[pwm_out_pkg::POS_FAULT_PIN_STATES];
      end
      // Polarity applied last so forced values are active levels
      nxt_st.pin_h = h_act ^ st_ff.ctrl[pwm_out_pkg::POS_POL_H];
      nxt_st.pin_l = l_act ^ st_ff.ctrl[pwm_out_pkg::POS_POL_L];
      nxt_st.oe_h  = st_ff.ctrl[pwm_out_pkg::POS_OWN_H];
      nxt_st.oe_l  = st_ff.ctrl[pwm_out_pkg::POS_OWN_L];
   end

   // State register
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         st_ff <= '{ctrl: pwm_out_pkg::CTRL_RESET, fmod_act: pwm_out_pkg::FMOD_LATCH,
                    key: pwm_out_pkg::KEY_IDLE, rdata: 32'h0000_0000, default: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from flip-flops
   assign RDATA         = st_ff.rdata;
   assign HIGH_SIDE_OUT = st_ff.pin_h;
   assign LOW_SIDE_OUT  = st_ff.pin_l;
   assign HIGH_SIDE_OE  = st_ff.oe_h;
   assign LOW_SIDE_OE   = st_ff.oe_l;
   assign FAULT_EVENT   = st_ff.fault_event;

   // Checks
   sequence key_pair_s;
      (WR && ADDR == pwm_out_pkg::ADDR_KEY && WDATA == pwm_out_pkg::KEY_FIRST) ##1
      (WR && ADDR == pwm_out_pkg::ADDR_KEY && WDATA == pwm_out_pkg::KEY_SECOND);
   endsequence
   sequence fault_on_s;
      st_ff.fault_sync && st_ff.fmod_act == pwm_out_pkg::FMOD_LATCH;
   endsequence

   AST_LOCKED_WRITE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      (WR && ADDR == pwm_out_pkg::ADDR_CTRL && !CONFIG_LOCK_FUSE && st_ff.key != pwm_out_pkg::KEY_OPEN)
      |=> $stable(st_ff.ctrl)) else $error("locked write changed control");
   AST_KEY_UNLOCK: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      key_pair_s |=> st_ff.key == pwm_out_pkg::KEY_OPEN) else $error("key pair did not unlock");
   AST_FUSE_WRITE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      (WR && ADDR == pwm_out_pkg::ADDR_CTRL && CONFIG_LOCK_FUSE)
      |=> st_ff.ctrl == ($past(WDATA) & pwm_out_pkg::CTRL_MASK)) else $error("fuse write lost");
   AST_LATCH_HOLD: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      fault_on_s |=> st_ff.fault_latch ##1 st_ff.fault_force) else $error("latched fault not held");
   AST_FAULT_PIN: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      st_ff.fault_force |=> HIGH_SIDE_OUT == ($past(st_ff.ctrl[pwm_out_pkg::POS_FAULT_PIN_STATES + 1]) ^
                                              $past(st_ff.ctrl[pwm_out_pkg::POS_POL_H])))
      else $error("fault state wrong on high pin");
   AST_MODE_BOUNDARY: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      !boundary |=> $stable(st_ff.fmod_act)) else $error("fault mode changed off boundary");
   AST_OFF_NO_FORCE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      (st_ff.fmod_act == pwm_out_pkg::FMOD_OFF && !st_ff.fault_latch && !st_ff.fault_force)
      |=> !st_ff.fault_force) else $error("disabled mode forced pins");
   AST_OWNERSHIP: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      ##1 (HIGH_SIDE_OE == $past(st_ff.ctrl[pwm_out_pkg::POS_OWN_H]) &&
           LOW_SIDE_OE == $past(st_ff.ctrl[pwm_out_pkg::POS_OWN_L])))
      else $error("pin enable not from ownership bits");
   AST_LOW_OFF: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      (st_ff.ctrl[pwm_out_pkg::POS_PIN_PAIR_MODE +: 2] == pwm_out_pkg::PIN_PAIR_MODE_LOWOFF && !st_ff.ovr_l && !st_ff.fault_force)
      |=> LOW_SIDE_OUT == $past(st_ff.ctrl[pwm_out_pkg::POS_POL_L])) else $error("low pin not held");

   // Pin checks start only from a sampled edge out of reset, pins lag by one
   sequence pin_free_h_s;
      RESET_N && !st_ff.fault_force && !st_ff.ovr_h;
   endsequence
   sequence pin_free_l_s;
      RESET_N && !st_ff.fault_force && !st_ff.ovr_l;
   endsequence
   sequence fault_edge_s;
      RESET_N && fault_raw && !st_ff.fault_sync;
   endsequence

   // Generator waveform through polarity on the high pin
   AST_POL_HIGH: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      pin_free_h_s |=> HIGH_SIDE_OUT == ($past(PWM_WAVE_H) ^ $past(st_ff.ctrl[pwm_out_pkg::POS_POL_H])))
      else $error("high pin not waveform");

   // Complementary low pin
   AST_COMP_LOW: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      pin_free_l_s ##0 (st_ff.ctrl[pwm_out_pkg::POS_PIN_PAIR_MODE +: 2] == pwm_out_pkg::PIN_PAIR_MODE_COMP)
      |=> LOW_SIDE_OUT == (!$past(PWM_WAVE_H) ^ $past(st_ff.ctrl[pwm_out_pkg::POS_POL_L])))
      else $error("complementary low pin wrong");

   // Redundant low pin copies the high waveform
   AST_REDUN_LOW: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      pin_free_l_s ##0 (st_ff.ctrl[pwm_out_pkg::POS_PIN_PAIR_MODE +: 2] == pwm_out_pkg::PIN_PAIR_MODE_REDUN)
      |=> LOW_SIDE_OUT == ($past(PWM_WAVE_H) ^ $past(st_ff.ctrl[pwm_out_pkg::POS_POL_L])))
      else $error("redundant low pin wrong");

   // Push-pull low pin follows its own waveform
   AST_PUSH_LOW: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      pin_free_l_s ##0 (st_ff.ctrl[pwm_out_pkg::POS_PIN_PAIR_MODE +: 2] == pwm_out_pkg::PIN_PAIR_MODE_PUSH)
      |=> LOW_SIDE_OUT == ($past(PWM_WAVE_L) ^ $past(st_ff.ctrl[pwm_out_pkg::POS_POL_L])))
      else $error("push-pull low pin wrong");

   // Override data on the high pin when no fault
   AST_OVR_HIGH: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      (RESET_N && st_ff.ovr_h && !st_ff.fault_force)
      |=> HIGH_SIDE_OUT == ($past(st_ff.ovr_dat[1]) ^ $past(st_ff.ctrl[pwm_out_pkg::POS_POL_H])))
      else $error("high override wrong");

   // Override data on the low pin when no fault
   AST_OVR_LOW: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      (RESET_N && st_ff.ovr_l && !st_ff.fault_force)
      |=> LOW_SIDE_OUT == ($past(st_ff.ovr_dat[0]) ^ $past(st_ff.ctrl[pwm_out_pkg::POS_POL_L])))
      else $error("low override wrong");

   // Fault state on the low pin, polarity adjusted
   AST_FAULT_LOW: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      st_ff.fault_force |=> LOW_SIDE_OUT == ($past(st_ff.ctrl[pwm_out_pkg::POS_FAULT_PIN_STATES]) ^
                                             $past(st_ff.ctrl[pwm_out_pkg::POS_POL_L])))
      else $error("fault state wrong on low pin");

   // Event pulse on every fault edge, whatever the mode
   AST_EVENT: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      fault_edge_s |=> FAULT_EVENT) else $error("fault edge gave no event");

   // Cycle mode forces at once
   AST_CYCLE_FORCE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      (st_ff.fault_sync && st_ff.fmod_act == pwm_out_pkg::FMOD_CYCLE) |=> st_ff.fault_force)
      else $error("cycle fault not forced");

   // Cycle mode releases at a boundary once the fault is gone
   AST_CYCLE_RELEASE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      (boundary && !st_ff.fault_sync && !st_ff.fault_latch && st_ff.fmod_act == pwm_out_pkg::FMOD_CYCLE)
      |=> !st_ff.fault_force) else $error("cycle fault not released");

   // Turning faults off keeps the override while the fault stands
   AST_HOLD_TO_OFF: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      (boundary && st_ff.ctrl[pwm_out_pkg::POS_FMOD +: 2] == pwm_out_pkg::FMOD_OFF && st_ff.fault_force &&
       st_ff.fault_sync) |=> $stable(st_ff.fmod_act)) else $error("override dropped on disable");

   // Reserved source codes never trip
   AST_SRC_RESERVED: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      (st_ff.ctrl[pwm_out_pkg::POS_FSRC +: 4] == 4'hD || st_ff.ctrl[pwm_out_pkg::POS_FSRC +: 4] == 4'hE)
      |-> !fault_raw) else $error("reserved source tripped");

   // Time-base high override enable moves only at a boundary
   AST_SYNC_OVR: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      (st_ff.ctrl[pwm_out_pkg::POS_OVERRIDE_SYNC_SELECT] && !boundary) |=> $stable(st_ff.ovr_h))
      else $error("synced override moved off boundary");

   // A read anywhere closes the key
   AST_KEY_DROP: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      RD |=> st_ff.key != pwm_out_pkg::KEY_OPEN) else $error("read left key open");
endmodule : pwm_output_fault_override_control

// ### testbench/fault_stage_model.sv
`timescale 1ns/10ps
// Fault lines into the block; only the selected line ever trips
module fault_stage_model (
   // Control from the bench
   input  wire logic        trip,
   input  wire logic        act_low,
   input  wire logic [3:0]  sel,
   // Lines into the block
   output logic      [15:0] lines
);
   // Idle lines rest at their inactive level so a wrong select never trips
   always_comb begin
      lines      = {16{act_low}};
      lines[sel] = trip ^ act_low;
   end
endmodule : fault_stage_model

// ### testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
   logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, fuse = 1'b0;
   logic        en = 1'b0, cs = 1'b0, wh = 1'b1, wl = 1'b1, cl = 1'b0;
   logic        trip = 1'b0, alow = 1'b0, ho, hoe, lo, loe, fev;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [15:0] flines;
   int          n_fail = 0, total_checks = 0, n_ev = 0;

   // Clock and event counter
   always #12.5 clk = ~clk;
   always @(posedge clk) if (fev === 1'b1) n_ev++;

   fault_stage_model partner (.trip(trip), .act_low(alow), .sel(4'h3), .lines(flines));
   pwm_output_fault_override_control dut (
      .SYS_CLK(clk), .RESET_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .CONFIG_LOCK_FUSE(fuse), .MODULE_ENABLE(en), .CYCLE_START(cs),
      .PWM_WAVE_H(wh), .PWM_WAVE_L(wl), .FAULT_SOURCES(flines), .CURRENT_LIMIT_ACTIVE(cl),
      .HIGH_SIDE_OUT(ho), .HIGH_SIDE_OE(hoe), .LOW_SIDE_OUT(lo), .LOW_SIDE_OE(loe),
      .FAULT_EVENT(fev));

   task automatic summarize;
      if (n_fail == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Every task starts and ends just after a rising edge
   task automatic step(input int n);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (n) @(posedge clk);
   endtask : step

   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
   endtask : wreg

   // Read data stand only in the cycle after the strobe
   task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
      addr <= a;
      wr   <= 1'b0;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
      @(posedge clk);
   endtask : rreg

   // Pins as {high oe, low oe, high, low}
   task automatic chkp(input logic [3:0] exp);
      #1 chk({28'h0, hoe, loe, ho, lo}, {28'h0, exp});
      @(posedge clk);
   endtask : chkp

   task automatic boundary;
      cs <= 1'b1;
      step(1);
      cs <= 1'b0;
      step(3);
   endtask : boundary

   task automatic restart(input logic f);
      rst_n <= 1'b0;
      fuse  <= f;
      en    <= 1'b0;
      trip  <= 1'b0;
      n_ev  = 0;
      step(6);
      rst_n <= 1'b1;
      @(posedge clk);
   endtask : restart

   // Key sequence gate with the lock fuse at 0
   task automatic s_lock;
      restart(1'b0);
      rreg(pwm_out_pkg::ADDR_CTRL, 32'h0);
      chkp(4'h2);
      wreg(pwm_out_pkg::ADDR_CTRL, 32'h0000_C000);
      rreg(pwm_out_pkg::ADDR_CTRL, 32'h0);
      wreg(pwm_out_pkg::ADDR_KEY, pwm_out_pkg::KEY_FIRST);
      wreg(pwm_out_pkg::ADDR_KEY, pwm_out_pkg::KEY_SECOND);
      rreg(8'h0C, 32'h0);
      wreg(pwm_out_pkg::ADDR_CTRL, 32'h0000_C000);
      rreg(pwm_out_pkg::ADDR_CTRL, 32'h0);
      wreg(pwm_out_pkg::ADDR_KEY, pwm_out_pkg::KEY_FIRST);
      wreg(pwm_out_pkg::ADDR_KEY, pwm_out_pkg::KEY_SECOND);
      wreg(pwm_out_pkg::ADDR_CTRL, 32'hFFFF_FFFF);
      rreg(pwm_out_pkg::ADDR_CTRL, pwm_out_pkg::CTRL_MASK);
      rreg(pwm_out_pkg::ADDR_KEY, 32'h0);
   endtask : s_lock

   // Pair modes, polarity and overrides with the module idle
   task automatic s_pins;
      logic [1:0] m;
      restart(1'b1);
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         wreg(pwm_out_pkg::ADDR_CTRL, {16'h0000, 4'hC, m, 10'h000});
         step(3);
         chkp({3'b111, i == 1 || i == 2});
      end
      wreg(pwm_out_pkg::ADDR_CTRL, 32'h0000_FC00);
      step(3);
      chkp(4'hD);
      wreg(pwm_out_pkg::ADDR_CTRL, 32'h0000_F340);
      step(3);
      chkp(4'hE);
      wreg(pwm_out_pkg::ADDR_CTRL, 32'h0);
      step(3);
      #1 chk({30'h0, hoe, loe}, 32'h0);
      @(posedge clk);
   endtask : s_pins

   // Cycle-by-cycle forcing over an override and a live current limit
   task automatic s_cycle;
      restart(1'b1);
      wreg(pwm_out_pkg::ADDR_CTRL, 32'h0119_C290);
      en <= 1'b1;
      cl <= 1'b1;
      step(2);
      boundary();
      chkp(4'hE);
      trip <= 1'b1;
      step(4);
      chkp(4'hD);
      chk(32'(n_ev), 32'h1);
      rreg(pwm_out_pkg::ADDR_STAT, 32'h3);
      trip <= 1'b0;
      step(4);
      chkp(4'hD);
      boundary();
      chkp(4'hE);
      cl <= 1'b0;
   endtask : s_cycle

   // Latched forcing on an active-low source, then mode 11
   task automatic s_latch;
      restart(1'b1);
      // Source flips with the polarity bit so no false fault latches
      wreg(pwm_out_pkg::ADDR_CTRL, 32'h001C_C010);
      alow <= 1'b1;
      en <= 1'b1;
      step(2);
      boundary();
      chkp(4'hE);
      trip <= 1'b1;
      step(4);
      chkp(4'hD);
      trip <= 1'b0;
      step(4);
      boundary();
      chkp(4'hD);
      trip <= 1'b1;
      wreg(pwm_out_pkg::ADDR_CTRL, 32'h001F_C010);
      step(3);
      boundary();
      chkp(4'hD);
      trip <= 1'b0;
      step(4);
      boundary();
      chkp(4'hE);
      trip <= 1'b1;
      step(4);
      chkp(4'hE);
      chk(32'(n_ev), 32'h3);
      alow <= 1'b0;
   endtask : s_latch

   // Main sequence
   initial begin
      s_lock();
      s_pins();
      s_cycle();
      s_latch();
      summarize();
   end

   // Watchdog well past the roughly 150 cycles the tests need
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      summarize();
   end
endmodule : testbench
